//--- host_bus_model.sv
// Host CPU model that drives the timer's parallel bus.
`timescale 1ns/1ps
module host_bus_model
(
  input  wire       sys_clk,
  input  wire [7:0] data_out,
  output reg        chip_sel_n  = 1'b1,
  output reg        rd_n        = 1'b1,
  output reg        wr_n        = 1'b1,
  output reg  [1:0] port_select = 2'h0,
  output reg  [7:0] data_in     = 8'h00
);
  // Callers issue the setup word before counts, and low bytes before high ones.
  // Strobes stay low six cycles and rest six, longer than the synchronisers need.
  task wr(input cs, input both, input [1:0] p, input [7:0] d);
  begin
    @(posedge sys_clk);
    chip_sel_n <= cs;
    port_select <= p;
    data_in <= d;
    wr_n <= 1'b0;
    rd_n <= !both;
    repeat (6) @(posedge sys_clk);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    chip_sel_n <= 1'b1;
    @(posedge sys_clk);
    data_in <= ~d;
    repeat (5) @(posedge sys_clk);
  end
  endtask

  // Read cycle; the byte is taken just before the strobe is released.
  task rd(input [1:0] p, output [7:0] d);
  begin
    @(posedge sys_clk);
    chip_sel_n <= 1'b0;
    port_select <= p;
    rd_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    d = data_out;
    rd_n <= 1'b1;
    chip_sel_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  end
  endtask
endmodule

//--- interval_timer.v
// Three-channel interval timer with its 8-bit host bus decoder.
`timescale 1ns/1ps
`include "interval_timer_consts.vh"
module interval_timer
#(
  parameter NUM_CH = 3
)
(
  input  wire              sys_clk,
  input  wire              rst_n,
  input  wire              chip_sel_n,
  input  wire              rd_n,
  input  wire              wr_n,
  input  wire [1:0]        port_select,
  input  wire [7:0]        data_in,
  output reg  [7:0]        data_out,
  output reg  [7:0]        data_oe_n,
  input  wire [NUM_CH-1:0] cnt_clk,
  input  wire [NUM_CH-1:0] count_gate,
  output reg  [NUM_CH-1:0] cnt_out
);

  reg  [1:0]        cs_s;
  reg  [1:0]        rd_s;
  reg  [1:0]        wr_s;
  reg  [1:0]        addr_s0;
  reg  [1:0]        addr_s1;
  reg  [7:0]        din_s0;
  reg  [7:0]        din_s1;
  reg               wr_act_q;
  reg               rd_act_q;
  reg  [1:0]        rd_port_q;
  wire              wr_now;
  wire              rd_now;
  wire              wr_start;
  wire              rd_end;
  wire [NUM_CH-1:0] setup_hit;
  wire [NUM_CH-1:0] data_hit;
  wire [NUM_CH-1:0] rd_hit;
  wire [NUM_CH-1:0] ch_out;
  wire [8*NUM_CH-1:0] ch_rd;
  reg  [7:0]        rd_mux;
  integer           k;

  // Bus pins are asynchronous to sys_clk; two flops before decoding.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cs_s    <= 2'h3;
      rd_s    <= 2'h3;
      wr_s    <= 2'h3;
      addr_s0 <= 2'h0;
      addr_s1 <= 2'h0;
      din_s0  <= 8'h00;
      din_s1  <= 8'h00;
    end
    else
    begin
      cs_s    <= {cs_s[0], chip_sel_n};
      rd_s    <= {rd_s[0], rd_n};
      wr_s    <= {wr_s[0], wr_n};
      addr_s0 <= port_select;
      addr_s1 <= addr_s0;
      din_s0  <= data_in;
      din_s1  <= din_s0;
    end
  end

  // Strobe qualification; both-low is treated as neither.
  assign wr_now   = !cs_s[1] && !wr_s[1] && rd_s[1];
  assign rd_now   = !cs_s[1] && !rd_s[1] && wr_s[1];
  assign wr_start = wr_now && !wr_act_q;
  assign rd_end   = rd_act_q && !rd_now;

  // One action per strobe: writes act on the leading edge, read pointers advance at the end.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_act_q  <= 1'b0;
      rd_act_q  <= 1'b0;
      rd_port_q <= `PORT_CNT0;
    end
    else
    begin
      wr_act_q <= wr_now;
      rd_act_q <= rd_now;
      if (rd_now && !rd_act_q)
      begin
        rd_port_q <= addr_s1[1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : ch
      // Channel index as a two-bit code, the width of the address and select fields.
      localparam [1:0] CH_ID = g;
      assign setup_hit[g] = wr_start && addr_s1[1:0] == `PORT_SETUP
                            && din_s1[`CW_SEL_HI:`CW_SEL_LO] == CH_ID
                            && din_s1[`CW_SEL_HI:`CW_SEL_LO] != `SEL_ILLEGAL;
      assign data_hit[g]  = wr_start && addr_s1[1:0] == CH_ID;
      assign rd_hit[g]    = rd_end && rd_port_q == CH_ID;
      timer_channel u_chan
      (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .cnt_clk      (cnt_clk[g]),
        .count_gate   (count_gate[g]),
        .setup_wr     (setup_hit[g]),
        .setup_bits   (din_s1[`CW_ACC_HI:`CW_BCD]),
        .data_wr      (data_hit[g]),
        .data_rd_done (rd_hit[g]),
        .wr_data      (din_s1),
        .rd_data      (ch_rd[8*g +: 8]),
        .cnt_out      (ch_out[g])
      );
    end
  endgenerate

  // Read mux; the setup port returns zero since its read is undefined.
  always @*
  begin
    rd_mux = 8'h00;
    for (k = 0; k < NUM_CH; k = k + 1)
    begin
      if (addr_s1[1:0] == k[1:0])
      begin
        rd_mux = ch_rd[8*k +: 8];
      end
    end
  end

  // Outputs are registered; the bus floats unless a read is in progress.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      data_out  <= 8'h00;
      data_oe_n <= `DATA_FLOAT_OE_N;
      cnt_out   <= {NUM_CH{1'b0}};
    end
    else
    begin
      data_out  <= rd_mux;
      data_oe_n <= rd_now ? 8'h00 : `DATA_FLOAT_OE_N;
      cnt_out   <= ch_out;
    end
  end

endmodule

//--- interval_timer_consts.vh
// Constants shared by the interval timer design files.
`ifndef INTERVAL_TIMER_CONSTS_VH
`define INTERVAL_TIMER_CONSTS_VH
`define PORT_CNT0        2'h0
`define PORT_CNT1        2'h1
`define PORT_CNT2        2'h2
`define PORT_SETUP       2'h3
`define CW_SEL_HI        7
`define CW_SEL_LO        6
`define CW_ACC_HI        5
`define CW_ACC_LO        4
`define CW_MODE_HI       3
`define CW_MODE_LO       1
`define CW_BCD           0
`define SEL_ILLEGAL      2'h3
`define ACC_LATCH        2'h0
`define ACC_LOW          2'h1
`define ACC_HIGH         2'h2
`define ACC_BOTH         2'h3
`define MODE_TC          3'h0
`define MODE_ONESHOT     3'h1
`define COUNT_CLEAR      16'h0000
`define COUNT_ONE        16'h0001
`define DATA_FLOAT_OE_N  8'hff
`endif

//--- interval_timer_sva.sv
// Concurrent checks on the interval timer's bus and counter outputs.
`timescale 1ns/1ps
module interval_timer_sva
#(
  parameter NUM_CH = 3
)
(
  input wire              sys_clk,
  input wire              rst_n,
  input wire              chip_sel_n,
  input wire              rd_n,
  input wire              wr_n,
  input wire [1:0]        port_select,
  input wire [7:0]        data_out,
  input wire [7:0]        data_oe_n,
  input wire [NUM_CH-1:0] cnt_clk,
  input wire [NUM_CH-1:0] cnt_out
);
  // Every check shares the system clock and its reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // The bus is driven only by a clean read with the device selected.
  a_float_cs_high: assert property (chip_sel_n [*6] |-> data_oe_n == 8'hff)
    else $error("bus driven while deselected");
  a_float_no_rd: assert property (rd_n [*6] |-> data_oe_n == 8'hff)
    else $error("bus driven without read");
  a_drive_on_rd: assert property ((!chip_sel_n && !rd_n && wr_n) [*6]
    |-> data_oe_n == 8'h00)
    else $error("bus not driven on read");
  a_both_low_idle: assert property ((!rd_n && !wr_n) [*6] |-> data_oe_n == 8'hff)
    else $error("bus driven with both strobes low");
  a_oe_all_bits: assert property (data_oe_n == 8'h00 || data_oe_n == 8'hff)
    else $error("bus partly driven");
  a_port3_zero: assert property (
    (!chip_sel_n && !rd_n && wr_n && port_select == 2'h3) [*6] |-> data_out == 8'h00)
    else $error("setup port read not zero");
  a_float_after_rd: assert property ($rose(rd_n) |-> ##[1:8] data_oe_n == 8'hff)
    else $error("bus not released after read");

  // An output moves only soon after its own clock rises or after a bus write.
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : ch
      reg       clk_q;
      reg [4:0] quiet_q;
      always @(posedge sys_clk)
      begin
        clk_q <= cnt_clk[g];
        if (!rst_n || !wr_n || (cnt_clk[g] && !clk_q))
          quiet_q <= 5'h00;
        else if (quiet_q != 5'h1f)
          quiet_q <= quiet_q + 5'h01;
      end
      a_out_needs_clk: assert property (quiet_q > 5'h10 |-> $stable(cnt_out[g]))
        else $error("output moved without its clock");
    end
  endgenerate
endmodule

bind interval_timer interval_timer_sva #(.NUM_CH(NUM_CH)) u_sva
  (.sys_clk(sys_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n),
   .port_select(port_select), .data_out(data_out), .data_oe_n(data_oe_n),
   .cnt_clk(cnt_clk), .cnt_out(cnt_out));

//--- programmable_interval_timer_test.sv
// Self-checking bench for the three-channel interval timer.
`timescale 1ns/1ps
module programmable_interval_timer_test;
  reg         sys_clk    = 1'b0;
  reg         rst_n      = 1'b0;
  reg  [2:0]  cnt_clk    = 3'h0;
  reg  [2:0]  count_gate = 3'h0;
  wire        chip_sel_n, rd_n, wr_n;
  wire [1:0]  port_select;
  wire [7:0]  data_in, data_out, data_oe_n;
  wire [2:0]  cnt_out;
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     k;
  reg  [15:0] n, v, x, t;

  always #5 sys_clk = ~sys_clk;

  interval_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
    .wr_n(wr_n), .port_select(port_select), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .cnt_clk(cnt_clk), .count_gate(count_gate), .cnt_out(cnt_out));
  host_bus_model host (.sys_clk(sys_clk), .data_out(data_out), .chip_sel_n(chip_sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .port_select(port_select), .data_in(data_in));

  // Compares one value and counts the outcome.
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  end
  endtask

  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  // One count step down, wrapping through 9999 in decimal and ffff in binary.
  function [15:0] dec(input [15:0] c, input bcd);
    integer d;
  begin
    d = bcd ? c[15:12] * 1000 + c[11:8] * 100 + c[7:4] * 10 + c[3:0] : c;
    d = bcd ? (d + 9999) % 10000 : (d + 65535) % 65536;
    dec = bcd ? {4'(d / 1000), 4'(d / 100 % 10), 4'(d / 10 % 10), 4'(d % 10)} : 16'(d);
  end
  endfunction

  // Counter clock pulses, slow enough for the synchronisers and output latency.
  task pulse(input integer ch, input integer cnt);
  begin
    repeat (cnt)
    begin
      @(posedge sys_clk);
      cnt_clk[ch] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      cnt_clk[ch] <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
  end
  endtask

  task setup(input [1:0] ch, input [1:0] acc, input [2:0] m, input b);
    host.wr(1'b0, 1'b0, 2'h3, {ch, acc, m, b});
  endtask

  task load(input [1:0] ch, input [15:0] c);
  begin
    host.wr(1'b0, 1'b0, ch, c[7:0]);
    host.wr(1'b0, 1'b0, ch, c[15:8]);
  end
  endtask

  // Latch command, then low byte and high byte.
  task lread(input [1:0] ch, output [15:0] c);
  begin
    setup(ch, 2'h0, 3'h0, 1'b0);
    host.rd(ch, c[7:0]);
    host.rd(ch, c[15:8]);
  end
  endtask

  // Pulses until the output is high, bounded so a dead counter cannot hang.
  task to_tc(input integer ch, output [15:0] cnt);
  begin
    cnt = 16'h0000;
    while (cnt_out[ch] !== 1'b1 && cnt < 16'd200)
    begin
      pulse(ch, 1);
      cnt = cnt + 16'h0001;
    end
  end
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end

  initial
  begin
    v = $urandom(95117);
    repeat (3) @(posedge sys_clk);
    chk(data_oe_n, 8'hff);
    chk(cnt_out, 3'h0);
    rst_n <= 1'b1;
    for (k = 0; k < 8; k = k + 1)
    begin
      setup(2'h2, 2'h3, k[2:0], 1'b0);
      chk(cnt_out[2], k != 0);
    end
    $display("test modes done");
    n = 16'(3 + $urandom % 6);
    count_gate[0] <= 1'b1;
    setup(2'h0, 2'h3, 3'h0, 1'b0);
    chk(cnt_out[0], 1'b0);
    load(2'h0, n);
    pulse(0, 2);
    count_gate[0] <= 1'b0;
    pulse(0, 3);
    lread(2'h0, v);
    chk(v, n - 16'h1);
    count_gate[0] <= 1'b1;
    to_tc(0, t);
    chk(t, n - 16'h1);
    pulse(0, 2);
    chk(cnt_out[0], 1'b1);
    $display("test mode0 done");
    for (k = 0; k < 4; k = k + 1)
    begin
      v = k == 2 ? 16'h0010 : k == 3 ? 16'($urandom) : 16'h0000;
      setup(2'h0, 2'h3, 3'h0, k[0] ^ k[1]);
      load(2'h0, v);
      pulse(0, 2);
      lread(2'h0, x);
      chk(x, dec(v, k[0] ^ k[1]));
    end
    $display("test formats done");
    count_gate[0] <= 1'b0;
    lread(2'h0, v);
    host.wr(1'b1, 1'b0, 2'h0, 8'h55);
    host.wr(1'b0, 1'b1, 2'h0, 8'h55);
    host.wr(1'b0, 1'b0, 2'h3, 8'hf0);
    lread(2'h0, x);
    chk(x, v);
    host.rd(2'h3, x[7:0]);
    chk(x[7:0], 8'h00);
    $display("test refusals done");
    count_gate[0] <= 1'b1;
    setup(2'h0, 2'h1, 3'h0, 1'b0);
    host.wr(1'b0, 1'b0, 2'h0, 8'h05);
    pulse(0, 2);
    host.wr(1'b0, 1'b0, 2'h0, 8'h02);
    to_tc(0, t);
    chk(t, 16'h3);
    setup(2'h0, 2'h3, 3'h0, 1'b0);
    load(2'h0, 16'h0004);
    pulse(0, 2);
    host.wr(1'b0, 1'b0, 2'h0, 8'h02);
    pulse(0, 4);
    chk(cnt_out[0], 1'b0);
    host.wr(1'b0, 1'b0, 2'h0, 8'h00);
    to_tc(0, t);
    chk(t, 16'h3);
    setup(2'h0, 2'h2, 3'h0, 1'b0);
    host.wr(1'b0, 1'b0, 2'h0, 8'h02);
    pulse(0, 2);
    lread(2'h0, x);
    chk(x, 16'h0101);
    setup(2'h0, 2'h3, 3'h0, 1'b0);
    load(2'h0, 16'h0001);
    to_tc(0, t);
    chk(t, 16'h2);
    $display("test rewrite done");
    n = 16'(2 + $urandom % 5);
    setup(2'h1, 2'h3, 3'h1, 1'b0);
    load(2'h1, n);
    pulse(1, 3);
    chk(cnt_out[1], 1'b1);
    count_gate[1] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pulse(1, 1);
    chk(cnt_out[1], 1'b0);
    count_gate[1] <= 1'b0;
    to_tc(1, t);
    chk(t, n);
    chk(cnt_out[0], 1'b1);
    $display("test mode1 done");
    tally_and_finish;
  end
endmodule

//--- timer_channel.v
// One down-counting channel of the interval timer with its own clock, gate and output.
`timescale 1ns/1ps
`include "interval_timer_consts.vh"
module timer_channel
(
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        cnt_clk,
  input  wire        count_gate,
  input  wire        setup_wr,
  input  wire [5:0]  setup_bits,
  input  wire        data_wr,
  input  wire        data_rd_done,
  input  wire [7:0]  wr_data,
  output reg  [7:0]  rd_data,
  output reg         cnt_out
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_WAIT  = 3'b010;
  localparam ST_RUN   = 3'b100;

  reg [1:0]  acc_q;
  reg [2:0]  mode_q;
  reg        bcd_q;
  reg [15:0] preset_q;
  reg [15:0] count_q;
  reg [15:0] latch_q;
  reg        latched_q;
  reg        wr_hi_next_q;
  reg        rd_hi_next_q;
  reg [2:0]  state_q;
  reg [2:0]  clk_s;
  reg [2:0]  gate_s;
  reg        load_pend_q;
  wire       clk_rise;
  wire       gate_rise;
  wire       gate_hi;
  wire [15:0] rd_word;

  // Decrement by one in binary or four-decade decimal; zero wraps to the top.
  function [15:0] dec_count;
    input [15:0] v;
    input        bcd;
    integer      i;
    reg          borrow;
    begin
      dec_count = v;
      borrow    = 1'b1;
      if (!bcd)
      begin
        dec_count = v - `COUNT_ONE;
      end
      else
      begin
        for (i = 0; i < 4; i = i + 1)
        begin
          if (borrow)
          begin
            if (v[i*4 +: 4] == 4'h0)
            begin
              dec_count[i*4 +: 4] = 4'h9;
            end
            else
            begin
              dec_count[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
              borrow              = 1'b0;
            end
          end
        end
      end
    end
  endfunction

  // Clock and gate pins come from outside, so two flops precede any use.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      clk_s  <= 3'h0;
      gate_s <= 3'h0;
    end
    else
    begin
      clk_s  <= {clk_s[1:0], cnt_clk};
      gate_s <= {gate_s[1:0], count_gate};
    end
  end

  assign clk_rise  = clk_s[1] & ~clk_s[2];
  assign gate_rise = gate_s[1] & ~gate_s[2];
  assign gate_hi   = gate_s[1];
  assign rd_word   = latched_q ? latch_q : count_q;

  // Setup, loading, latching and counting share one process since all touch the count.
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      acc_q        <= `ACC_BOTH;
      mode_q       <= `MODE_TC;
      bcd_q        <= 1'b0;
      preset_q     <= `COUNT_CLEAR;
      count_q      <= `COUNT_CLEAR;
      latch_q      <= `COUNT_CLEAR;
      latched_q    <= 1'b0;
      wr_hi_next_q <= 1'b0;
      rd_hi_next_q <= 1'b0;
      state_q      <= ST_IDLE;
      load_pend_q  <= 1'b0;
      cnt_out      <= 1'b0;
    end
    else if (setup_wr && setup_bits[5:4] != `ACC_LATCH)
    begin
      acc_q        <= setup_bits[5:4];
      mode_q       <= {setup_bits[3] & ~setup_bits[2], setup_bits[2:1]};
      bcd_q        <= setup_bits[0];
      count_q      <= `COUNT_CLEAR;
      latched_q    <= 1'b0;
      wr_hi_next_q <= 1'b0;
      rd_hi_next_q <= 1'b0;
      state_q      <= ST_IDLE;
      load_pend_q  <= 1'b0;
      cnt_out      <= (setup_bits[3:1] != `MODE_TC);
    end
    else
    begin
      if (data_rd_done)
      begin
        if (acc_q == `ACC_BOTH && !rd_hi_next_q)
        begin
          rd_hi_next_q <= 1'b1;
        end
        else
        begin
          rd_hi_next_q <= 1'b0;
          latched_q    <= 1'b0;
        end
      end
      // A latch command is taken beside the counting logic, so no counter clock is lost.
      if (setup_wr && !latched_q)
      begin
        latch_q   <= count_q;
        latched_q <= 1'b1;
      end
      if (data_wr)
      begin
        case (acc_q)
          `ACC_LOW:
          begin
            preset_q    <= {8'h00, wr_data};
            load_pend_q <= 1'b1;
          end
          `ACC_HIGH:
          begin
            preset_q    <= {wr_data, 8'h00};
            load_pend_q <= 1'b1;
          end
          default:
          begin
            if (!wr_hi_next_q)
            begin
              preset_q[7:0] <= wr_data;
              wr_hi_next_q  <= 1'b1;
              if (mode_q == `MODE_TC)
              begin
                state_q <= ST_IDLE;
              end
            end
            else
            begin
              preset_q[15:8] <= wr_data;
              wr_hi_next_q   <= 1'b0;
              load_pend_q    <= 1'b1;
            end
          end
        endcase
        if (mode_q == `MODE_TC && acc_q != `ACC_BOTH)
        begin
          state_q <= ST_IDLE;
        end
      end
      else if (mode_q == `MODE_TC)
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (load_pend_q)
            begin
              state_q <= ST_WAIT;
              cnt_out <= 1'b0;
            end
          end
          ST_WAIT:
          begin
            // The new count is taken on the first clock edge after loading.
            if (clk_rise)
            begin
              count_q     <= preset_q;
              load_pend_q <= 1'b0;
              state_q     <= ST_RUN;
            end
          end
          ST_RUN:
          begin
            if (clk_rise && gate_hi)
            begin
              count_q <= dec_count(count_q, bcd_q);
              if (count_q == `COUNT_ONE)
              begin
                cnt_out <= 1'b1;
              end
            end
          end
          default:
          begin
            state_q <= ST_IDLE;
          end
        endcase
      end
      if (mode_q != `MODE_TC)
      begin
        // Every mode but 0 runs as one-shot: only a gate rising edge arms a run from the preset.
        // A host write does not pause a run in progress, so no clock is lost.
        case (state_q)
          ST_IDLE:
          begin
            if (gate_rise && (load_pend_q || preset_q != `COUNT_CLEAR))
            begin
              state_q <= ST_WAIT;
            end
          end
          ST_WAIT:
          begin
            if (clk_rise)
            begin
              count_q     <= preset_q;
              load_pend_q <= 1'b0;
              cnt_out     <= 1'b0;
              state_q     <= ST_RUN;
            end
          end
          ST_RUN:
          begin
            // A gate drop does not stop the run; a retrigger reloads.
            if (gate_rise)
            begin
              state_q <= ST_WAIT;
            end
            else if (clk_rise)
            begin
              count_q <= dec_count(count_q, bcd_q);
              if (count_q == `COUNT_ONE)
              begin
                cnt_out <= 1'b1;
                state_q <= ST_IDLE;
              end
            end
          end
          default:
          begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Read byte follows the access format; a latched value wins over the live count.
  always @*
  begin
    case (acc_q)
      `ACC_HIGH: rd_data = rd_word[15:8];
      `ACC_BOTH: rd_data = rd_hi_next_q ? rd_word[15:8] : rd_word[7:0];
      default:   rd_data = rd_word[7:0];
    endcase
  end

endmodule
